/* design/drv_status_regs.sv */
// Function
// - Overcurrent flag, bit 3, follows drain-source comparator: set above, clear below.
// - High-side undervoltage flag, bit 2, is valid only while gate_uv_check_off is zero.
// - High-side undervoltage flag reads one below gate threshold, zero above it.
// - Regulator undervoltage flag, bit 0, reads one below 92% of target, else zero.
// - Revision register upper nibble always reads zero.
// - Revision register lower nibble returns the fixed silicon revision code.
//
// Local design decisions: the address map and the strobed register port.
`default_nettype none
module drv_status_regs
(
    input  wire logic                  clk,             // System clock, 125 MHz.
    input  wire logic                  arst_n,          // Asynchronous reset, active low.
    input  wire logic                  ce,              // Clock enable; low freezes all state.
    input  wire drv_status_pkg::addr_t addr,            // Register address.
    input  wire drv_status_pkg::byte_t wdata,           // Write data.
    input  wire logic                  wr_en,           // Write strobe, one cycle.
    input  wire logic                  rd_en,           // Read strobe, one cycle.
    output var  drv_status_pkg::byte_t rdata,           // Read data, cycle after rd_en.
    output logic                       irq,             // Level interrupt, active high.
    input  wire logic                  vds_over_pin,    // Drain-source comparator, high = over.
    input  wire logic                  hs_gate_low_pin, // Gate-drive comparator, high = low.
    input  wire logic                  vreg_low_pin     // Regulator comparator, high = below 92%.
);
    import drv_status_pkg::*;

    // ------------------------------------------------------------------
    // Comparator conditioning
    // ------------------------------------------------------------------
    sense_if sense ();

    assign sense.raw[SENSE_OC]  = vds_over_pin;
    assign sense.raw[SENSE_HS]  = hs_gate_low_pin;
    assign sense.raw[SENSE_REG] = vreg_low_pin;

    sense_sync u_sync
    (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .s      (sense)
    );

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic wr_cfg, wr_mask, rd_stat, rd_events;

    assign wr_cfg    = ce && wr_en && (addr == ADDR_CONFIG_REG_ZERO);
    assign wr_mask   = ce && wr_en && (addr == ADDR_EVENT_MASK);
    assign rd_stat   = ce && rd_en && (addr == ADDR_STATUS_SECONDARY);
    assign rd_events = ce && rd_en && (addr == ADDR_EVENT_STATUS);

    // ------------------------------------------------------------------
    // Configuration and status state
    // ------------------------------------------------------------------
    byte_t config_reg_zero_reg, config_reg_zero_next;
    byte_t status_reg_secondary_reg, status_reg_secondary_next;
    byte_t event_status_reg, event_status_next;
    byte_t event_mask_reg, event_mask_next;
    byte_t rdata_reg, rdata_next;
    logic  gate_uv_check_off, short_detect_config;
    byte_t live_status, rising;

    assign gate_uv_check_off   = config_reg_zero_reg[BIT_UV_CHECK_OFF];
    assign short_detect_config = config_reg_zero_reg[BIT_SHORT_DETECT];

    always_comb
    begin
        live_status = ZERO_BYTE;
        live_status[BIT_OVERCURRENT] = sense.clean[SENSE_OC] && short_detect_config;
        // A disabled gate check reports clear rather than a stale level.
        live_status[BIT_HS_UV] = sense.clean[SENSE_HS] && !gate_uv_check_off;
        live_status[BIT_REG_UV] = sense.clean[SENSE_REG];
        live_status = live_status & STATUS_IMPL;
    end

    always_comb
    begin
        config_reg_zero_next      = config_reg_zero_reg;
        event_mask_next           = event_mask_reg;
        status_reg_secondary_next = status_reg_secondary_reg;
        event_status_next         = event_status_reg;
        rising                    = live_status & ~status_reg_secondary_reg;
        if (ce)
        begin
            status_reg_secondary_next = live_status;
            if (wr_cfg)
            begin
                config_reg_zero_next = wdata & CONFIG_IMPL;
            end
            if (wr_mask)
            begin
                event_mask_next = wdata & STATUS_IMPL;
            end
            if (rd_events)
            begin
                event_status_next = ZERO_BYTE;
            end
            // A new event in the clearing read's cycle survives the clear.
            event_status_next = event_status_next | rising;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Status and revision have no write path at all, so a write to their
    // offsets falls through with no effect.
    always_comb
    begin
        rdata_next = rdata_reg;
        if (ce)
        begin
            rdata_next = ZERO_BYTE;
            if (rd_en)
            begin
                case (addr)
                    ADDR_STATUS_SECONDARY:  rdata_next = status_reg_secondary_reg;
                    ADDR_HARDWARE_REVISION:
                    begin
                        rdata_next = ZERO_BYTE;
                        rdata_next[REV_LSB +: REV_W] = SILICON_REV;
                    end
                    ADDR_CONFIG_REG_ZERO:   rdata_next = config_reg_zero_reg;
                    ADDR_EVENT_STATUS:      rdata_next = event_status_reg;
                    ADDR_EVENT_MASK:        rdata_next = event_mask_reg;
                    default:                rdata_next = ZERO_BYTE;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            config_reg_zero_reg      <= RESET_CONFIG;
            status_reg_secondary_reg <= RESET_STATUS;
            event_status_reg         <= RESET_EVENTS;
            event_mask_reg           <= RESET_MASK;
            rdata_reg                <= ZERO_BYTE;
        end
        else
        begin
            config_reg_zero_reg      <= config_reg_zero_next;
            status_reg_secondary_reg <= status_reg_secondary_next;
            event_status_reg         <= event_status_next;
            event_mask_reg           <= event_mask_next;
            rdata_reg                <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign irq   = |(event_status_reg & event_mask_reg);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_overcurrent;
        ce && short_detect_config |=>
            status_reg_secondary_reg[BIT_OVERCURRENT] == $past(sense.clean[SENSE_OC]);
    endproperty
    a_overcurrent: assert property (p_overcurrent)
        else $error("Overcurrent flag does not follow its comparator.");

    property p_oc_gated;
        ce && !short_detect_config |=> !status_reg_secondary_reg[BIT_OVERCURRENT];
    endproperty
    a_oc_gated: assert property (p_oc_gated)
        else $error("Overcurrent flag set while detection is off.");

    property p_hs_uv_gated;
        ce && gate_uv_check_off |=> !status_reg_secondary_reg[BIT_HS_UV];
    endproperty
    a_hs_uv_gated: assert property (p_hs_uv_gated)
        else $error("High-side undervoltage flag set while check is off.");

    property p_hs_uv_level;
        ce && !gate_uv_check_off |=>
            status_reg_secondary_reg[BIT_HS_UV] == $past(sense.clean[SENSE_HS]);
    endproperty
    a_hs_uv_level: assert property (p_hs_uv_level)
        else $error("High-side undervoltage flag does not follow its comparator.");

    property p_reg_uv;
        ce ##1 ce |-> status_reg_secondary_reg[BIT_REG_UV] == $past(sense.clean[SENSE_REG]);
    endproperty
    a_reg_uv: assert property (p_reg_uv)
        else $error("Regulator undervoltage flag does not follow its comparator.");

    property p_rev_upper;
        ce && rd_en && addr == ADDR_HARDWARE_REVISION |=>
            (rdata >> (REV_LSB + REV_W)) == ZERO_BYTE;
    endproperty
    a_rev_upper: assert property (p_rev_upper)
        else $error("Revision upper nibble not zero.");

    property p_rev_code;
        ce && rd_en && addr == ADDR_HARDWARE_REVISION |=> rdata[REV_LSB +: REV_W] == SILICON_REV;
    endproperty
    a_rev_code: assert property (p_rev_code)
        else $error("Revision code wrong.");

    property p_status_unimpl;
        rd_stat |=> (rdata & ~STATUS_IMPL) == ZERO_BYTE && rdata == $past(status_reg_secondary_reg);
    endproperty
    a_status_unimpl: assert property (p_status_unimpl)
        else $error("Status read returned unimplemented bits or wrong value.");

    property p_irq_level;
        // An unmasked new event must raise the line, even beside a clearing read.
        ce && (|(rising & event_mask_reg)) && !wr_mask |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("Interrupt output disagrees with masked events.");

    property p_event_clear;
        rd_events && rising == ZERO_BYTE |=> event_status_reg == ZERO_BYTE;
    endproperty
    a_event_clear: assert property (p_event_clear)
        else $error("Event status not cleared by read.");

    c_rev_read:  cover property (ce && rd_en && addr == ADDR_HARDWARE_REVISION);
    c_irq_rise:  cover property (!irq ##1 irq);
    c_hs_uv_set: cover property (status_reg_secondary_reg[BIT_HS_UV]);
    c_oc_set:    cover property (status_reg_secondary_reg[BIT_OVERCURRENT] ##1 rd_stat);

endmodule // drv_status_regs
`default_nettype wire

/* design/drv_status_pkg.sv */
`default_nettype none
package drv_status_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_STATUS_SECONDARY = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_HARDWARE_REVISION = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG_REG_ZERO   = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_EVENT_STATUS      = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_EVENT_MASK        = 8'h04;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_OVERCURRENT  = 3;
    localparam int BIT_HS_UV        = 2;
    localparam int BIT_REG_UV       = 0;
    localparam int BIT_UV_CHECK_OFF = 3;
    localparam int BIT_SHORT_DETECT = 0;
    localparam int REV_LSB          = 0;
    localparam int REV_W            = 4;
    localparam int NUM_SENSE        = 3;

    // Index of each comparator within the sense vector.
    localparam int SENSE_OC  = 0;
    localparam int SENSE_HS  = 1;
    localparam int SENSE_REG = 2;

    // ------------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] RESET_STATUS   = 8'h00;
    localparam logic [DATA_W-1:0] RESET_CONFIG   = 8'h01;
    localparam logic [DATA_W-1:0] RESET_EVENTS   = 8'h00;
    localparam logic [DATA_W-1:0] RESET_MASK     = 8'h00;
    localparam logic [DATA_W-1:0] STATUS_IMPL    = 8'h0D;
    localparam logic [DATA_W-1:0] CONFIG_IMPL    = 8'h09;
    localparam logic [DATA_W-1:0] ZERO_BYTE      = 8'h00;

    // Arbitrary neutral silicon revision code.
    localparam logic [REV_W-1:0]  SILICON_REV    = 4'h1;

    typedef logic [DATA_W-1:0] byte_t;
    typedef logic [ADDR_W-1:0] addr_t;

endpackage : drv_status_pkg
`default_nettype wire

/* design/sense_if.sv */
`default_nettype none
interface sense_if;
    logic [drv_status_pkg::NUM_SENSE-1:0] raw;
    logic [drv_status_pkg::NUM_SENSE-1:0] clean;
    modport conditioner (input raw, output clean);
    modport consumer (output raw, input clean);
endinterface : sense_if
`default_nettype wire

/* design/sense_sync.sv */
`default_nettype none
module sense_sync
(
    input  wire logic clk,          // System clock.
    input  wire logic arst_n,       // Asynchronous reset, active low.
    input  wire logic ce,           // Clock enable.
    sense_if.conditioner s          // Raw comparator levels in, settled levels out.
);
    import drv_status_pkg::*;

    // ------------------------------------------------------------------
    // Three-stage capture per comparator
    // ------------------------------------------------------------------
    // A level is taken only once stages two and three agree, so a single
    // metastable resolution cannot make a flag blip for one cycle.
    genvar g;
    generate
        for (g = 0; g < NUM_SENSE; g++)
        begin : g_bit
            logic s1_reg, s2_reg, s3_reg, clean_reg, clean_next;

            always_comb
            begin
                clean_next = (s2_reg == s3_reg) ? s3_reg : clean_reg;
            end

            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    s1_reg    <= 1'b0;
                    s2_reg    <= 1'b0;
                    s3_reg    <= 1'b0;
                    clean_reg <= 1'b0;
                end
                else if (ce)
                begin
                    s1_reg    <= s.raw[g];
                    s2_reg    <= s1_reg;
                    s3_reg    <= s2_reg;
                    clean_reg <= clean_next;
                end
            end

            assign s.clean[g] = clean_reg;
        end
    endgenerate

endmodule // sense_sync
`default_nettype wire

/* bench/host_model.sv */
`default_nettype none
module host_model
(
    input  wire logic                  clk,   // System clock.
    output var  drv_status_pkg::addr_t addr,  // Register address.
    output var  drv_status_pkg::byte_t wdata, // Write data.
    output var  logic                  wr_en, // Write strobe.
    output var  logic                  rd_en, // Read strobe.
    input  wire drv_status_pkg::byte_t rdata  // Read data.
);
    timeunit 1ns;
    timeprecision 1ps;
    import drv_status_pkg::*;

    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    initial
    begin
        addr  = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end

    task automatic write_reg(input addr_t a, input byte_t d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // The data are taken just after the edge that follows the strobe,
    // because they stand for that one cycle only.
    task automatic read_reg(input addr_t a, output byte_t d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
endmodule // host_model
`default_nettype wire

/* bench/tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import drv_status_pkg::*;

    logic  clk    = 1'b0;
    logic  arst_n = 1'b0;
    logic  ce     = 1'b1;
    logic  vds    = 1'b0;
    logic  hs     = 1'b0;
    logic  vreg   = 1'b0;
    addr_t addr;
    byte_t wdata;
    logic  wr_en;
    logic  rd_en;
    byte_t rdata;
    logic  irq;
    int    miscompares = 0;
    int    tests_run   = 0;

    always #4 clk = ~clk;

    host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
                     .rd_en(rd_en), .rdata(rdata));

    drv_status_regs dut (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata),
                         .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
                         .vds_over_pin(vds), .hs_gate_low_pin(hs), .vreg_low_pin(vreg));

    // ------------------------------------------------------------------
    // Compare and helper tasks
    // ------------------------------------------------------------------
    task automatic check_byte(input byte_t got, input byte_t exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_check(input addr_t a, input byte_t exp);
        byte_t d;
        host.read_reg(a, d);
        check_byte(d, exp);
    endtask

    // Eight edges cover the synchroniser and status latency with margin.
    task automatic set_pins(input logic [2:0] v);
        @(posedge clk);
        {vds, hs, vreg} <= v;
        repeat (8) @(posedge clk);
    endtask

    task automatic stop_test();
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        rd_check(ADDR_STATUS_SECONDARY, 8'h00);
        rd_check(ADDR_HARDWARE_REVISION, {4'h0, SILICON_REV});
        rd_check(ADDR_CONFIG_REG_ZERO, 8'h01);
        rd_check(ADDR_EVENT_MASK, 8'h00);
        rd_check(8'h10, 8'h00);
        check_bit(irq, 1'b0);
    endtask

    task automatic test_ro_writes();
        host.write_reg(ADDR_STATUS_SECONDARY, 8'hFF);
        host.write_reg(ADDR_HARDWARE_REVISION, 8'hFF);
        rd_check(ADDR_STATUS_SECONDARY, 8'h00);
        rd_check(ADDR_HARDWARE_REVISION, {4'h0, SILICON_REV});
    endtask

    task automatic test_flags();
        set_pins(3'b100);
        rd_check(ADDR_STATUS_SECONDARY, 8'h08);
        set_pins(3'b000);
        rd_check(ADDR_STATUS_SECONDARY, 8'h00);
        set_pins(3'b010);
        rd_check(ADDR_STATUS_SECONDARY, 8'h04);
        host.write_reg(ADDR_CONFIG_REG_ZERO, 8'h09);
        set_pins(3'b010);
        rd_check(ADDR_STATUS_SECONDARY, 8'h00);
        host.write_reg(ADDR_CONFIG_REG_ZERO, 8'h01);
        set_pins(3'b001);
        rd_check(ADDR_STATUS_SECONDARY, 8'h01);
        set_pins(3'b000);
        rd_check(ADDR_STATUS_SECONDARY, 8'h00);
    endtask

    // Rising edges seen above: overcurrent, high-side twice, regulator.
    task automatic test_irq();
        rd_check(ADDR_EVENT_STATUS, 8'h0D);
        rd_check(ADDR_EVENT_STATUS, 8'h00);
        host.write_reg(ADDR_EVENT_MASK, 8'h01);
        set_pins(3'b001);
        check_bit(irq, 1'b1);
        rd_check(ADDR_EVENT_STATUS, 8'h01);
        check_bit(irq, 1'b0);
        set_pins(3'b011);
        check_bit(irq, 1'b0);
        rd_check(ADDR_EVENT_STATUS, 8'h04);
        rd_check(ADDR_STATUS_SECONDARY, 8'h05);
        set_pins(3'b000);
    endtask

    // With the enable low a pin change must go unseen until it returns, and a read strobe must be lost.
    task automatic test_ce();
        @(posedge clk);
        ce <= 1'b0;
        set_pins(3'b001);
        check_bit(irq, 1'b0);
        rd_check(ADDR_HARDWARE_REVISION, 8'h00);
        @(posedge clk);
        ce <= 1'b1;
        set_pins(3'b001);
        check_bit(irq, 1'b1);
        rd_check(ADDR_EVENT_STATUS, 8'h01);
        check_bit(irq, 1'b0);
        set_pins(3'b000);
    endtask

    // Detection off hides the overcurrent flag; a reset mid-run restores defaults.
    task automatic test_cfg_reset();
        host.write_reg(ADDR_CONFIG_REG_ZERO, 8'hFF);
        rd_check(ADDR_CONFIG_REG_ZERO, 8'h09);
        host.write_reg(ADDR_CONFIG_REG_ZERO, 8'h00);
        set_pins(3'b110);
        rd_check(ADDR_STATUS_SECONDARY, 8'h04);
        set_pins(3'b000);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd_check(ADDR_CONFIG_REG_ZERO, 8'h01);
        rd_check(ADDR_EVENT_STATUS, 8'h00);
        rd_check(ADDR_EVENT_MASK, 8'h00);
        check_bit(irq, 1'b0);
        set_pins(3'b100);
        rd_check(ADDR_STATUS_SECONDARY, 8'h08);
        set_pins(3'b000);
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        test_reset();
        test_ro_writes();
        test_flags();
        test_irq();
        test_ce();
        test_cfg_reset();
        stop_test();
    end

    initial
    begin
        #50000;
        miscompares++;
        stop_test();
    end
endmodule // tb
`default_nettype wire
